//--- design/accel_core_end.sv
`timescale 1ns/100ps
module accel_core_end (
  // Clock, reset, mode
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic big_endian_i,
  // Execution set from decode
  input wire logic es_valid_i,
  input wire logic es_prefixed_i,
  input wire logic [accel_port_pkg::SLOTS-1:0] es_slot_valid_i,
  input wire accel_port_pkg::word_t [accel_port_pkg::SLOTS-1:0] es_op_i,
  // Parallel move of the execution set
  input wire accel_port_pkg::core_move_e mv_kind_i,
  input wire logic mv_bus_b_i,
  input wire accel_port_pkg::word_t mv_addr_i,
  input wire logic [accel_port_pkg::ARITH_IDX_W-1:0] mv_arith_idx_i,
  input wire accel_port_pkg::word_t mv_arith_val_i,
  input wire accel_port_pkg::word_t mv_core_val_i,
  // Memory address and control
  output logic mem_req_o,
  output logic mem_write_o,
  output logic mem_bus_b_o,
  output accel_port_pkg::word_t mem_addr_o,
  // Register write-back
  output logic arith_wr_o,
  output logic [accel_port_pkg::ARITH_IDX_W-1:0] arith_wr_idx_o,
  output accel_port_pkg::word_t arith_wr_data_o,
  output logic core_reg_wr_o,
  output accel_port_pkg::word_t core_reg_data_o,
  // Accelerator link
  accel_link_if.core link
);
  import accel_port_pkg::*;

  // ==========================================================
  // Opcode recognition
  logic [SLOTS-1:0] slot_hit;
  logic hit_any;
  acc_opcode_t hit_op;
  logic es_accel;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign slot_hit[g] = (g != 0) && es_prefixed_i && es_slot_valid_i[g]
                         && (es_op_i[g][WORD_W-1 -: PFX_W] == ACCEL_PREFIX); // [RQ1] [RQ2]
    end
  endgenerate

  // Lowest later slot wins; extra hits are dropped
  always_comb begin
    hit_any = 1'b0;
    hit_op = OPC_RST;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (slot_hit[i]) begin
        hit_any = 1'b1;
        hit_op = es_op_i[i][OPC_W-1:0]; // [RQ1]
      end
    end
  end

  assign es_accel = es_valid_i && hit_any;

  // ==========================================================
  // Dispatch stage
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link.disp_valid <= 1'b0;
      link.disp_op <= OPC_RST;
    end else begin
      link.disp_valid <= es_accel; // [RQ18]
      link.disp_op <= es_accel ? hit_op : OPC_RST;
    end
  end

  core_move_e s1_kind;
  core_move_e s2_kind;
  logic s1_accel;
  logic s2_accel;
  logic s1_bus_b;
  logic s2_bus_b;
  logic [ARITH_IDX_W-1:0] s1_idx;
  logic [ARITH_IDX_W-1:0] s2_idx;
  word_t s1_addr;
  word_t s1_arith;
  word_t s2_arith;
  word_t s1_core;
  word_t s2_core;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s1_kind <= MV_NONE;
      s1_accel <= 1'b0;
      s1_bus_b <= 1'b0;
      s1_idx <= ARITH_IDX_RST;
      s1_addr <= WORD_RST;
      s1_arith <= WORD_RST;
      s1_core <= WORD_RST;
    end else begin
      s1_kind <= es_valid_i ? mv_kind_i : MV_NONE;
      s1_accel <= es_accel;
      s1_bus_b <= mv_bus_b_i;
      s1_idx <= mv_arith_idx_i;
      s1_addr <= mv_addr_i;
      s1_arith <= mv_arith_val_i;
      s1_core <= mv_core_val_i;
    end
  end

  // ==========================================================
  // Access stage: address always, data only without accelerator
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mem_req_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_bus_b_o <= 1'b0;
      mem_addr_o <= WORD_RST;
    end else begin
      mem_req_o <= (s1_kind == MV_MEM_LOAD) || (s1_kind == MV_MEM_STORE); // [RQ9] [RQ6]
      mem_write_o <= s1_kind == MV_MEM_STORE;
      mem_bus_b_o <= s1_bus_b;
      mem_addr_o <= s1_addr; // [RQ6]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link.core_a_oe <= 1'b0;
      link.core_b_oe <= 1'b0;
      link.core_a_data <= WORD_RST;
      link.core_b_data <= WORD_RST;
      link.reg_bus_core_valid <= 1'b0;
      link.reg_bus_core <= WORD_RST;
    end else begin
      link.core_a_oe <= (s1_kind == MV_MEM_STORE) && !s1_accel && !s1_bus_b; // [RQ7]
      link.core_b_oe <= (s1_kind == MV_MEM_STORE) && !s1_accel && s1_bus_b; // [RQ7]
      link.core_a_data <= order_bytes(s1_arith, big_endian_i);
      link.core_b_data <= order_bytes(s1_arith, big_endian_i);
      link.reg_bus_core_valid <= s1_accel
        && ((s1_kind == MV_CORE_TO_ARITH) || (s1_kind == MV_IMM_TO_ARITH)); // [RQ12] [RQ15] [RQ13]
      link.reg_bus_core <= s1_core;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s2_kind <= MV_NONE;
      s2_accel <= 1'b0;
      s2_bus_b <= 1'b0;
      s2_idx <= ARITH_IDX_RST;
      s2_arith <= WORD_RST;
      s2_core <= WORD_RST;
    end else begin
      s2_kind <= s1_kind;
      s2_accel <= s1_accel;
      s2_bus_b <= s1_bus_b;
      s2_idx <= s1_idx;
      s2_arith <= s1_arith;
      s2_core <= s1_core;
    end
  end

  // ==========================================================
  // Write-back: arithmetic register left alone beside accelerator
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      arith_wr_o <= 1'b0;
      arith_wr_idx_o <= ARITH_IDX_RST;
      arith_wr_data_o <= WORD_RST;
      core_reg_wr_o <= 1'b0;
      core_reg_data_o <= WORD_RST;
    end else begin
      arith_wr_o <= !s2_accel && ((s2_kind == MV_MEM_LOAD) || (s2_kind == MV_CORE_TO_ARITH)
                    || (s2_kind == MV_IMM_TO_ARITH)); // [RQ7] [RQ11] [RQ15]
      arith_wr_idx_o <= s2_idx;
      arith_wr_data_o <= (s2_kind == MV_MEM_LOAD)
        ? order_bytes(s2_bus_b ? link.data_bus_b : link.data_bus_a, big_endian_i) : s2_core;
      core_reg_wr_o <= s2_kind == MV_ARITH_TO_CORE;
      core_reg_data_o <= s2_accel ? link.reg_bus_acc : s2_arith; // [RQ11] [RQ13]
    end
  end

endmodule

//--- design/accel_link_if.sv
`timescale 1ns/100ps
interface accel_link_if;
  import accel_port_pkg::*;

  // ==========================================================
  // Dispatch
  logic disp_valid;
  acc_opcode_t disp_op;

  // ==========================================================
  // Shared data buses, one drive pair per party
  word_t core_a_data;
  logic core_a_oe;
  word_t core_b_data;
  logic core_b_oe;
  word_t acc_a_data;
  logic acc_a_oe;
  word_t acc_b_data;
  logic acc_b_oe;
  word_t mem_a_data;
  logic mem_a_oe;
  word_t mem_b_data;
  logic mem_b_oe;
  word_t data_bus_a;
  word_t data_bus_b;

  // ==========================================================
  // Core-accelerator register buses
  word_t reg_bus_core;
  logic reg_bus_core_valid;
  word_t reg_bus_acc;
  logic reg_bus_acc_oe;

  // Wired-OR of enabled drivers; a clash shows as a merged value
  assign data_bus_a = (core_a_oe ? core_a_data : WORD_RST) | (acc_a_oe ? acc_a_data : WORD_RST)
                    | (mem_a_oe ? mem_a_data : WORD_RST);
  assign data_bus_b = (core_b_oe ? core_b_data : WORD_RST) | (acc_b_oe ? acc_b_data : WORD_RST)
                    | (mem_b_oe ? mem_b_data : WORD_RST);

  modport core (
    output disp_valid, disp_op, core_a_data, core_a_oe, core_b_data, core_b_oe,
    output reg_bus_core, reg_bus_core_valid,
    input data_bus_a, data_bus_b, reg_bus_acc, reg_bus_acc_oe
  );

  modport accel (
    input disp_valid, disp_op, data_bus_a, data_bus_b, reg_bus_core, reg_bus_core_valid,
    output acc_a_data, acc_a_oe, acc_b_data, acc_b_oe, reg_bus_acc, reg_bus_acc_oe
  );

endinterface

//--- design/accel_plugin_end.sv
`timescale 1ns/100ps
// Operation
// RQ1: Accelerator opcode never first; one per set
// RQ2: Prefix 0011101, two words, 25 free bits
// RQ3: Top opcode bits carry accelerator select code
// RQ4: Arithmetic runs in core-like pipeline, no addressing
// RQ5: Memory data over buses A/B, registers separately
// RQ6: No address unit here; core makes addresses
// RQ7: Core ignores arithmetic register beside accelerator
// RQ8: Accelerator only drives/samples data, never addresses
// RQ9: Each data transfer paired with core address move
// RQ10: Byte order handled exactly as core does
// RQ11: Long moves skip arithmetic register beside accelerator
// RQ12: Core drives source register onto register bus
// RQ13: Register transfers split, complementary directions on bus
// RQ14: Incoming transfer only samples bus into register
// RQ15: Immediate goes on register bus, not loaded
// RQ16: Set semantics and dependencies between sets kept
// RQ17: One opcode may hold parallel accelerator instructions
// RQ18: Dispatch bus carries at most one opcode per set
// RQ19: Only the selected accelerator acts on opcode
// RQ20: Buses driven only in access cycle, else released
module accel_plugin_end #(
  parameter logic SELECT_EN = 1'b1,
  parameter logic [accel_port_pkg::SEL_W-1:0] SELECT_CODE = 3'h0
) (
  // Clock, reset, mode
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic big_endian_i,
  // Register observation
  input wire logic [accel_port_pkg::ACC_IDX_W-1:0] peek_idx_i,
  output accel_port_pkg::word_t peek_data_o,
  output logic sel_hit_o,
  // Core link
  accel_link_if.accel link
);
  import accel_port_pkg::*;

  // ==========================================================
  // Dispatch decode
  word_t kreg [ACC_REGS];
  logic take;
  acc_move_e d_mv;
  alu_op_e d_alu;
  logic [ACC_IDX_W-1:0] d_mreg;
  logic [ACC_IDX_W-1:0] d_dst;
  logic [ACC_IDX_W-1:0] d_s1;
  logic [ACC_IDX_W-1:0] d_s2;

  // Select check off for a single-accelerator system
  assign take = link.disp_valid
    && (!SELECT_EN || (link.disp_op[SEL_LSB +: SEL_W] == SELECT_CODE)); // [RQ3] [RQ19]

  // Move and arithmetic slots decoded side by side
  always_comb begin
    d_mv = AM_NONE;
    d_alu = ALU_NOP;
    d_mreg = link.disp_op[MREG_LSB +: ACC_IDX_W];
    d_dst = link.disp_op[DST_LSB +: ACC_IDX_W];
    d_s1 = link.disp_op[SRC1_LSB +: ACC_IDX_W];
    d_s2 = link.disp_op[SRC2_LSB +: ACC_IDX_W];
    if (take) begin
      d_mv = acc_move_e'(link.disp_op[MV_LSB +: MV_W]); // [RQ17]
      d_alu = alu_op_e'(link.disp_op[ALU_LSB +: ALU_W]); // [RQ17]
    end
  end

  // ==========================================================
  // Execute stage, one cycle after dispatch
  acc_move_e x_mv;
  alu_op_e x_alu;
  logic [ACC_IDX_W-1:0] x_mreg;
  logic [ACC_IDX_W-1:0] x_dst;
  logic [ACC_IDX_W-1:0] x_s1;
  logic [ACC_IDX_W-1:0] x_s2;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      x_mv <= AM_NONE;
      x_alu <= ALU_NOP;
      x_mreg <= ACC_IDX_RST;
      x_dst <= ACC_IDX_RST;
      x_s1 <= ACC_IDX_RST;
      x_s2 <= ACC_IDX_RST;
      sel_hit_o <= 1'b0;
    end else begin
      x_mv <= d_mv;
      x_alu <= d_alu;
      x_mreg <= d_mreg;
      x_dst <= d_dst;
      x_s1 <= d_s1;
      x_s2 <= d_s2;
      sel_hit_o <= take;
    end
  end

  // ==========================================================
  // Results of the executing set
  logic mw_en;
  word_t mw_data;
  logic aw_en;
  word_t aw_data;

  always_comb begin
    mw_en = 1'b0;
    mw_data = WORD_RST;
    unique case (x_mv)
      AM_LOAD_A: begin
        mw_en = 1'b1;
        mw_data = order_bytes(link.data_bus_a, big_endian_i); // [RQ5] [RQ8] [RQ10]
      end
      AM_LOAD_B: begin
        mw_en = 1'b1;
        mw_data = order_bytes(link.data_bus_b, big_endian_i); // [RQ5] [RQ8] [RQ10]
      end
      AM_FROM_CORE: begin
        mw_en = 1'b1;
        mw_data = link.reg_bus_core; // [RQ14] [RQ13]
      end
      AM_NONE, AM_STORE_A, AM_STORE_B, AM_TO_CORE: begin
        mw_en = 1'b0;
      end
      default: begin
        mw_en = 1'b0;
      end
    endcase
  end

  // Arithmetic needs no address; timed like the core arithmetic stage
  always_comb begin
    aw_en = x_alu != ALU_NOP; // [RQ4]
    unique case (x_alu)
      ALU_NOP: aw_data = WORD_RST;
      ALU_ADD: aw_data = kreg[x_s1] + kreg[x_s2]; // [RQ4]
      ALU_SUB: aw_data = kreg[x_s1] - kreg[x_s2]; // [RQ4]
      ALU_XOR: aw_data = kreg[x_s1] ^ kreg[x_s2]; // [RQ4]
    endcase
  end

  // Move write after the arithmetic one, so a move wins on a shared target
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < ACC_REGS; i++) begin
        kreg[i] <= WORD_RST;
      end
    end else begin
      if (aw_en) begin
        kreg[x_dst] <= aw_data; // [RQ16]
      end
      if (mw_en) begin
        kreg[x_mreg] <= mw_data; // [RQ16]
      end
    end
  end

  // ==========================================================
  // Outgoing data, forwarded from the set now finishing
  word_t src_fwd;

  // Bypass keeps back-to-back sets dependent without a stall
  always_comb begin
    src_fwd = kreg[d_mreg];
    if (aw_en && (x_dst == d_mreg)) begin
      src_fwd = aw_data; // [RQ16]
    end
    if (mw_en && (x_mreg == d_mreg)) begin
      src_fwd = mw_data; // [RQ16]
    end
  end

  // Enables last exactly the access cycle, then release
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link.acc_a_oe <= 1'b0;
      link.acc_b_oe <= 1'b0;
      link.acc_a_data <= WORD_RST;
      link.acc_b_data <= WORD_RST;
      link.reg_bus_acc_oe <= 1'b0;
      link.reg_bus_acc <= WORD_RST;
    end else begin
      link.acc_a_oe <= d_mv == AM_STORE_A; // [RQ20] [RQ8] [RQ9]
      link.acc_b_oe <= d_mv == AM_STORE_B; // [RQ20] [RQ8] [RQ9]
      link.acc_a_data <= order_bytes(src_fwd, big_endian_i); // [RQ10]
      link.acc_b_data <= order_bytes(src_fwd, big_endian_i); // [RQ10]
      link.reg_bus_acc_oe <= d_mv == AM_TO_CORE; // [RQ13] [RQ20]
      link.reg_bus_acc <= src_fwd;
    end
  end

  // ==========================================================
  // Observation port
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      peek_data_o <= WORD_RST;
    end else begin
      peek_data_o <= kreg[peek_idx_i];
    end
  end

endmodule

//--- design/accel_port_pkg.sv
package accel_port_pkg;

  // ==========================================================
  // Widths and counts
  localparam int SLOTS = 4;
  localparam int WORD_W = 32;
  localparam int OPC_WORDS = 2;
  localparam int OPC_W = 25;
  localparam int PFX_W = 7;
  localparam logic [PFX_W-1:0] ACCEL_PREFIX = 7'h1D;
  localparam int ARITH_IDX_W = 4;
  localparam int ACC_REGS = 8;
  localparam int ACC_IDX_W = 3;

  // ==========================================================
  // Accelerator opcode fields
  localparam int SEL_W = 3;
  localparam int SEL_LSB = 22;
  localparam int MV_LSB = 19;
  localparam int MV_W = 3;
  localparam int MREG_LSB = 16;
  localparam int ALU_LSB = 14;
  localparam int ALU_W = 2;
  localparam int DST_LSB = 11;
  localparam int SRC1_LSB = 8;
  localparam int SRC2_LSB = 5;

  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;
  localparam logic [OPC_W-1:0] OPC_RST = 25'h0000000;
  localparam logic [ARITH_IDX_W-1:0] ARITH_IDX_RST = 4'h0;
  localparam logic [ACC_IDX_W-1:0] ACC_IDX_RST = 3'h0;

  // ==========================================================
  // Types
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [OPC_W-1:0] acc_opcode_t;

  typedef enum logic [2:0] {
    MV_NONE,
    MV_MEM_LOAD,
    MV_MEM_STORE,
    MV_CORE_TO_ARITH,
    MV_ARITH_TO_CORE,
    MV_IMM_TO_ARITH
  } core_move_e;

  typedef enum logic [MV_W-1:0] {
    AM_NONE,
    AM_LOAD_A,
    AM_LOAD_B,
    AM_STORE_A,
    AM_STORE_B,
    AM_FROM_CORE,
    AM_TO_CORE
  } acc_move_e;

  typedef enum logic [ALU_W-1:0] {
    ALU_NOP,
    ALU_ADD,
    ALU_SUB,
    ALU_XOR
  } alu_op_e;

  // Byte lanes reversed in big-endian mode, shared by both ends
  function automatic word_t order_bytes(input word_t w, input logic big);
    order_bytes = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

endpackage

//--- verif/accel_port_chk.sv
`timescale 1ns/100ps
module accel_port_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Link signals
  input wire logic disp_valid,
  input wire accel_port_pkg::acc_opcode_t disp_op,
  input wire logic core_a_oe,
  input wire logic core_b_oe,
  input wire logic acc_a_oe,
  input wire logic acc_b_oe,
  input wire logic reg_bus_core_valid,
  input wire logic reg_bus_acc_oe
);
  import accel_port_pkg::*;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // ==========================================================
  // Dispatch of one move kind to the selected plug-in
  sequence s_disp(logic [2:0] mv);
    disp_valid && disp_op[24:22] == 3'h0 && disp_op[21:19] == mv;
  endsequence

  // Remember last cycle's dispatch; plain $past of an expression is avoided
  logic store_a_q;
  logic store_b_q;
  logic to_core_q;
  always_ff @(posedge sys_clk_i) begin
    store_a_q <= !srst_i && disp_valid && disp_op[24:22] == 3'h0 && disp_op[21:19] == AM_STORE_A;
    store_b_q <= !srst_i && disp_valid && disp_op[24:22] == 3'h0 && disp_op[21:19] == AM_STORE_B;
    to_core_q <= !srst_i && disp_valid && disp_op[24:22] == 3'h0 && disp_op[21:19] == AM_TO_CORE;
  end

  // ==========================================================
  // Bus ownership
  a_oe_excl_a: assert property (!(core_a_oe && acc_a_oe))
    else $error("bus A driven by both ends");
  a_oe_excl_b: assert property (!(core_b_oe && acc_b_oe))
    else $error("bus B driven by both ends");
  a_store_a_drive: assert property (s_disp(AM_STORE_A) |=> acc_a_oe)
    else $error("store to bus A not driven");
  a_store_b_drive: assert property (s_disp(AM_STORE_B) |=> acc_b_oe)
    else $error("store to bus B not driven");
  a_acc_a_release: assert property (acc_a_oe |-> store_a_q)
    else $error("bus A driven outside access cycle");
  a_acc_b_release: assert property (acc_b_oe |-> store_b_q)
    else $error("bus B driven outside access cycle");
  a_core_quiet_a: assert property (disp_valid |=> !core_a_oe)
    else $error("core drove bus A beside accelerator");
  a_core_quiet_b: assert property (disp_valid |=> !core_b_oe)
    else $error("core drove bus B beside accelerator");
  a_regbus_core: assert property (reg_bus_core_valid |-> $past(disp_valid))
    else $error("register bus driven without accelerator");
  a_disp_idle: assert property (!disp_valid |-> disp_op == OPC_RST)
    else $error("opcode not idle between dispatches");
  a_to_core_drive: assert property (s_disp(AM_TO_CORE) |=> reg_bus_acc_oe && to_core_q)
    else $error("transfer to core not driven");
  a_to_core_rel: assert property (reg_bus_acc_oe |-> to_core_q)
    else $error("register bus held outside transfer");
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import accel_port_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic big_endian_i = 1'b0;
  logic es_valid_i = 1'b0;
  logic es_prefixed_i = 1'b0;
  logic [SLOTS-1:0] es_slot_valid_i = 4'h0;
  word_t [SLOTS-1:0] es_op_i = '0;
  core_move_e mv_kind_i = MV_NONE;
  logic mv_bus_b_i = 1'b0;
  word_t mv_addr_i = WORD_RST;
  logic [ARITH_IDX_W-1:0] mv_arith_idx_i = ARITH_IDX_RST;
  word_t mv_arith_val_i = WORD_RST;
  word_t mv_core_val_i = WORD_RST;
  logic [ACC_IDX_W-1:0] peek_idx_i = ACC_IDX_RST;
  logic mem_req_o, mem_write_o, mem_bus_b_o, arith_wr_o, core_reg_wr_o, sel_hit_o;
  word_t mem_addr_o, arith_wr_data_o, core_reg_data_o, peek_data_o;
  logic [ARITH_IDX_W-1:0] arith_wr_idx_o;
  logic [ARITH_IDX_W-1:0] r_awi;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic r_disp, r_req, r_wr, r_bb, r_coe, r_hit, r_rbv, r_awr, r_crw;
  word_t r_addr, r_bus, r_rbc, r_awd, r_crd;
  acc_opcode_t r_op;
  word_t k2v = 32'h12345678;

  accel_link_if link_i();
  accel_core_end accel_core_end_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .big_endian_i(big_endian_i),
    .es_valid_i(es_valid_i), .es_prefixed_i(es_prefixed_i), .es_slot_valid_i(es_slot_valid_i), .es_op_i(es_op_i),
    .mv_kind_i(mv_kind_i), .mv_bus_b_i(mv_bus_b_i), .mv_addr_i(mv_addr_i), .mv_arith_idx_i(mv_arith_idx_i),
    .mv_arith_val_i(mv_arith_val_i), .mv_core_val_i(mv_core_val_i), .mem_req_o(mem_req_o),
    .mem_write_o(mem_write_o), .mem_bus_b_o(mem_bus_b_o), .mem_addr_o(mem_addr_o), .arith_wr_o(arith_wr_o),
    .arith_wr_idx_o(arith_wr_idx_o), .arith_wr_data_o(arith_wr_data_o), .core_reg_wr_o(core_reg_wr_o),
    .core_reg_data_o(core_reg_data_o), .link(link_i));
  accel_plugin_end accel_plugin_end_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .big_endian_i(big_endian_i),
    .peek_idx_i(peek_idx_i), .peek_data_o(peek_data_o), .sel_hit_o(sel_hit_o), .link(link_i));
  accel_port_chk accel_port_chk_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .disp_valid(link_i.disp_valid),
    .disp_op(link_i.disp_op), .core_a_oe(link_i.core_a_oe), .core_b_oe(link_i.core_b_oe),
    .acc_a_oe(link_i.acc_a_oe), .acc_b_oe(link_i.acc_b_oe), .reg_bus_core_valid(link_i.reg_bus_core_valid),
    .reg_bus_acc_oe(link_i.reg_bus_acc_oe));

  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================
  // Helpers
  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is about a hundred cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end

  function automatic acc_opcode_t mk(input logic [2:0] sel, input acc_move_e mv, input logic [2:0] r,
      input alu_op_e alu, input logic [8:0] regs);
    mk = {sel, mv, r, alu, regs, 5'h00};
  endfunction

  // One set; move inputs held until the set has finished, so sets are not overlapped
  task automatic send(input logic pre, input logic [6:0] pfx, input int slot, input acc_opcode_t op,
      input core_move_e k, input logic bb, input word_t aval, input word_t cval, input word_t memd);
    word_t [SLOTS-1:0] ops;
    ops = '0;
    if (slot >= 0) begin
      ops[slot] = {pfx, op};
    end
    @(posedge sys_clk_i);
    es_valid_i <= 1'b1;
    es_prefixed_i <= pre;
    es_slot_valid_i <= (slot < 0) ? 4'h1 : 4'h1 | (4'h1 << slot);
    es_op_i <= ops;
    mv_kind_i <= k;
    mv_bus_b_i <= bb;
    mv_addr_i <= 32'h00000A40;
    mv_arith_val_i <= aval;
    mv_core_val_i <= cval;
    @(posedge sys_clk_i);
    es_valid_i <= 1'b0;
    #1 r_disp = link_i.disp_valid;
    r_op = link_i.disp_op;
    @(posedge sys_clk_i);
    link_i.mem_a_oe <= (k == MV_MEM_LOAD) && !bb;
    link_i.mem_b_oe <= (k == MV_MEM_LOAD) && bb;
    link_i.mem_a_data <= memd;
    link_i.mem_b_data <= memd;
    #1 r_req = mem_req_o;
    r_wr = mem_write_o;
    r_bb = mem_bus_b_o;
    r_addr = mem_addr_o;
    r_coe = link_i.core_a_oe | link_i.core_b_oe;
    r_hit = sel_hit_o;
    r_bus = bb ? link_i.data_bus_b : link_i.data_bus_a;
    r_rbv = link_i.reg_bus_core_valid;
    r_rbc = link_i.reg_bus_core;
    @(posedge sys_clk_i);
    link_i.mem_a_oe <= 1'b0;
    link_i.mem_b_oe <= 1'b0;
    mv_kind_i <= MV_NONE;
    #1 r_awr = arith_wr_o;
    r_awi = arith_wr_idx_o;
    r_awd = arith_wr_data_o;
    r_crw = core_reg_wr_o;
    r_crd = core_reg_data_o;
  endtask

  task automatic peek(input logic [2:0] idx, input word_t exp);
    @(posedge sys_clk_i);
    peek_idx_i <= idx;
    repeat (2) @(posedge sys_clk_i);
    #1 `CHK(peek_data_o, exp)
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    link_i.mem_a_oe = 1'b0;
    link_i.mem_b_oe = 1'b0;
    link_i.mem_a_data = WORD_RST;
    link_i.mem_b_data = WORD_RST;
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    // Slot 0, unprefixed set, wrong prefix, then a proper one
    for (int i = 0; i < 4; i++) begin
      send(i != 1, (i == 2) ? 7'h1C : ACCEL_PREFIX, i, acc_opcode_t'(32'h00000010 + i), MV_NONE, 1'b0, WORD_RST,
        WORD_RST, WORD_RST);
      `CHK(r_disp, i == 3)
    end
    `CHK(r_op, 25'h0000013)
    send(1'b1, ACCEL_PREFIX, 1, mk(3'h0, AM_FROM_CORE, 3'h2, ALU_NOP, 9'h000), MV_CORE_TO_ARITH, 1'b0,
      32'hDEAD0000, k2v, WORD_RST);
    `CHK(r_rbv, 1'b1)
    `CHK(r_rbc, k2v)
    `CHK(r_awr, 1'b0)
    `CHK(r_hit, 1'b1)
    peek(3'h2, k2v);
    send(1'b1, ACCEL_PREFIX, 2, mk(3'h0, AM_FROM_CORE, 3'h3, ALU_NOP, 9'h000), MV_IMM_TO_ARITH, 1'b0,
      WORD_RST, 32'h00001234, WORD_RST);
    `CHK(r_rbc, 32'h00001234)
    `CHK(r_awr, 1'b0)
    // Move and add packed in one opcode
    send(1'b1, ACCEL_PREFIX, 1, mk(3'h0, AM_FROM_CORE, 3'h7, ALU_ADD, {3'h6, 3'h2, 3'h3}), MV_CORE_TO_ARITH,
      1'b0, WORD_RST, 32'h000000C7, WORD_RST);
    peek(3'h6, k2v + 32'h00001234);
    peek(3'h7, 32'h000000C7);
    for (int e = 0; e < 2; e++) begin
      @(posedge sys_clk_i);
      big_endian_i <= e[0];
      // Little-endian store on bus A, big-endian store on bus B
      send(1'b1, ACCEL_PREFIX, 2, mk(3'h0, e ? AM_STORE_B : AM_STORE_A, 3'h2, ALU_NOP, 9'h000), MV_MEM_STORE,
        e[0], 32'hFFFF0000, WORD_RST, WORD_RST);
      `CHK(r_req, 1'b1)
      `CHK(r_bb, e[0])
      `CHK(r_wr, 1'b1)
      `CHK(r_addr, 32'h00000A40)
      `CHK(r_coe, 1'b0)
      `CHK(r_bus, e ? {k2v[7:0], k2v[15:8], k2v[23:16], k2v[31:24]} : k2v)
    end
    @(posedge sys_clk_i);
    big_endian_i <= 1'b0;
    send(1'b1, ACCEL_PREFIX, 3, mk(3'h0, AM_LOAD_B, 3'h4, ALU_NOP, 9'h000), MV_MEM_LOAD, 1'b1,
      WORD_RST, WORD_RST, 32'hA5C30F96);
    `CHK(r_bb, 1'b1)
    `CHK(r_awr, 1'b0)
    peek(3'h4, 32'hA5C30F96);
    // Big-endian load on bus A beside an XOR, then a SUB
    @(posedge sys_clk_i);
    big_endian_i <= 1'b1;
    send(1'b1, ACCEL_PREFIX, 1, mk(3'h0, AM_LOAD_A, 3'h1, ALU_XOR, {3'h0, 3'h2, 3'h3}), MV_MEM_LOAD, 1'b0,
      WORD_RST, WORD_RST, 32'h01020304);
    peek(3'h1, 32'h04030201);
    peek(3'h0, k2v ^ 32'h00001234);
    send(1'b1, ACCEL_PREFIX, 1, mk(3'h0, AM_NONE, 3'h0, ALU_SUB, {3'h0, 3'h2, 3'h3}), MV_NONE, 1'b0,
      WORD_RST, WORD_RST, WORD_RST);
    peek(3'h0, k2v - 32'h00001234);
    @(posedge sys_clk_i);
    big_endian_i <= 1'b0;
    // Same moves without an accelerator in the set, then a transfer to core and a set for another accelerator
    send(1'b1, ACCEL_PREFIX, -1, OPC_RST, MV_MEM_STORE, 1'b1, 32'h0BADF00D, WORD_RST, WORD_RST);
    `CHK(r_disp, 1'b0)
    `CHK(r_coe, 1'b1)
    `CHK(r_bus, 32'h0BADF00D)
    @(posedge sys_clk_i);
    mv_arith_idx_i <= 4'h9;
    send(1'b1, ACCEL_PREFIX, -1, OPC_RST, MV_MEM_LOAD, 1'b0, WORD_RST, WORD_RST, 32'h55AA1234);
    `CHK(r_awr, 1'b1)
    `CHK(r_awd, 32'h55AA1234)
    `CHK(r_awi, 4'h9)
    send(1'b1, ACCEL_PREFIX, -1, OPC_RST, MV_ARITH_TO_CORE, 1'b0, 32'h77777777, WORD_RST, WORD_RST);
    `CHK(r_crw, 1'b1)
    `CHK(r_crd, 32'h77777777)
    send(1'b1, ACCEL_PREFIX, 1, mk(3'h0, AM_TO_CORE, 3'h2, ALU_NOP, 9'h000), MV_ARITH_TO_CORE, 1'b0,
      32'h77777777, WORD_RST, WORD_RST);
    `CHK(r_crw, 1'b1)
    `CHK(r_crd, k2v)
    send(1'b1, ACCEL_PREFIX, 1, mk(3'h1, AM_FROM_CORE, 3'h5, ALU_NOP, 9'h000), MV_CORE_TO_ARITH, 1'b0,
      WORD_RST, 32'h0000CAFE, WORD_RST);
    `CHK(r_hit, 1'b0)
    peek(3'h5, WORD_RST);
    summarize();
  end
endmodule
